// [logic/rrs_pkg.sv]
// Constants, register map and types for the receive status signalling block
// Contract
// - In MII at 100 Mb/s receive error goes high with the receive clock for an invalid symbol inside a frame.
// - In RMII at 100 Mb/s receive error goes high on the reference clock for a media error while data valid is high.
// - In RMII the received data is corrupted on a receive error so a MAC ignoring the error pin still drops the frame.
// - In MII received data leaves as nibbles on the receive clock, 25 MHz at 100 Mb/s and 2.5 MHz at 10 Mb/s.
// - The MII data nibble means something only while data valid is high and the MAC ignores it otherwise.
// - In RMII received data leaves two bits per cycle on the 50 MHz reference clock.
// - In MII carrier sense is high exactly while the receive medium is not idle.
// - In RMII one output merges carrier and data valid the way the published RMII carrier/data-valid signal does.
// - In MII half duplex collision is high while transmit and receive are active together.
// - In 10BASE-T half duplex with heartbeat on, collision also pulses for about 1 us after each transmission.
// - In full duplex collision stays low and no heartbeat pulse is made.
// - In MII the device supplies the recovered receive clock, 25 MHz at 100 Mb/s and 2.5 MHz at 10 Mb/s.
// - In RMII a separate data valid output shows valid data regardless of carrier.
package rrs_pkg;
  localparam int          CLK_PERIOD_NS = 8;
  localparam int          HB_TIME_NS    = 1000;
  localparam int          HB_CYCLES     = HB_TIME_NS / CLK_PERIOD_NS;
  localparam int          ADR_W         = 4;
  localparam int          DAT_W         = 32;
  localparam int          SEL_W         = 4;
  localparam int          NIB_W         = 4;
  localparam int          DIBIT_W       = 2;
  localparam int          ERR_CNT_W     = 16;
  localparam logic [3:0]  ADDR_CTRL     = 4'h0;
  localparam logic [3:0]  ADDR_STAT     = 4'h4;
  localparam logic [3:0]  ADDR_ERRCNT   = 4'h8;
  localparam int          CTRL_W        = 4;
  localparam int          CTRL_RMII     = 0;
  localparam int          CTRL_SPEED100 = 1;
  localparam int          CTRL_FDX      = 2;
  localparam int          CTRL_HB_EN    = 3;
  localparam logic [3:0]  CTRL_RESET    = 4'hA;
  localparam int          STAT_CARRIER  = 0;
  localparam int          STAT_DV       = 1;
  localparam int          STAT_COL      = 2;
  localparam int          STAT_ER       = 3;
  localparam int          STAT_DRAIN    = 4;
  localparam logic [1:0]  CORRUPT_DIBIT = 2'h1;

  typedef enum logic [1:0] {RRS_IDLE, RRS_FRAME, RRS_DRAIN} rrs_rx_state_type;
endpackage : rrs_pkg

// [logic/rrs_edge_sync.sv]
// Two-flop synchroniser with edge detection for an outside clock or level
`timescale 1ns/1ns
module rrs_edge_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Outside signal
  input  wire logic async_i,
  // Synchronised level and edges
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } rrs_sync_state_type;

  rrs_sync_state_type q, n;

  always_comb begin
    n      = q;
    n.meta = async_i;
    n.sync = q.meta;
    n.last = q.sync;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // Edges look only at the second and third flops, never the first
  assign level_o = q.sync;
  assign rise_o  = q.sync & ~q.last;
  assign fall_o  = ~q.sync & q.last;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  edge_once_a: assert property (fall_o |=> !fall_o) else $error("fall pulse longer than a cycle");
endmodule : rrs_edge_sync

// [logic/rrs_col_gen.sv]
// Collision and heartbeat generator
`timescale 1ns/1ns
module rrs_col_gen #(
  parameter int HB_CYCLES = rrs_pkg::HB_CYCLES
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Activity and mode
  input  wire logic tx_active_i,
  input  wire logic carrier_i,
  input  wire logic half_mii_i,
  input  wire logic sqe_en_i,
  // Collision pin
  output logic      col_o
);
  import rrs_pkg::*;

  localparam int HB_W = $clog2(HB_CYCLES + 1);

  if (HB_CYCLES < 1) begin : g_bad_hb
    $error("heartbeat length must be at least one cycle");
  end

  typedef struct packed {
    logic            tx;
    logic [HB_W-1:0] hb_cnt;
    logic            col;
  } rrs_col_state_type;

  rrs_col_state_type q, n;

  always_comb begin
    n    = q;
    n.tx = tx_active_i;
    if (q.tx && !tx_active_i && sqe_en_i) begin
      n.hb_cnt = HB_W'(HB_CYCLES);
    end else if (q.hb_cnt != '0) begin
      n.hb_cnt = q.hb_cnt - 1'b1;
    end
    // Full duplex or RMII kills a running heartbeat at once
    if (!half_mii_i) begin
      n.hb_cnt = '0;
    end
    n.col = half_mii_i && ((tx_active_i && carrier_i) || n.hb_cnt != '0);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign col_o = q.col;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence sqe_start;
    $fell(tx_active_i) && sqe_en_i && half_mii_i;
  endsequence

  col_overlap_a: assert property (half_mii_i && tx_active_i && carrier_i |=> col_o)
    else $error("overlap without collision");
  sqe_pulse_a: assert property (sqe_start ##1 half_mii_i |-> col_o [*8])
    else $error("heartbeat pulse too short");
endmodule : rrs_col_gen

// [logic/rrs_rx_signal.sv]
// Receive status signalling toward the MAC over MII or RMII, with a Wishbone slave
//
// The Wishbone slave port and the address map were left to the implementer.
`timescale 1ns/1ns
module rrs_rx_signal #(
  parameter int ERR_CNT_W = rrs_pkg::ERR_CNT_W
) (
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // Wishbone slave
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [rrs_pkg::ADR_W-1:0]  wb_adr_i,
  input  wire logic [rrs_pkg::SEL_W-1:0]  wb_sel_i,
  input  wire logic [rrs_pkg::DAT_W-1:0]  wb_dat_i,
  output logic      [rrs_pkg::DAT_W-1:0]  wb_dat_o,
  output logic                            wb_ack_o,
  // Link clocks from outside
  input  wire logic                       rec_clock_i,
  input  wire logic                       ref_clock_in_i,
  // Receiver core side
  input  wire logic                       core_carrier_i,
  input  wire logic                       core_dv_i,
  input  wire logic [rrs_pkg::NIB_W-1:0]  core_data_i,
  input  wire logic                       core_err_i,
  input  wire logic                       core_tx_active_i,
  output logic                            core_take_o,
  // MAC receive pins
  output logic                            rx_clk_o,
  output logic      [rrs_pkg::NIB_W-1:0]  rx_data_o,
  output logic                            rx_dv_o,
  output logic                            rx_er_o,
  output logic                            crs_o,
  output logic                            col_o
);
  import rrs_pkg::*;

  if (ERR_CNT_W < 1 || ERR_CNT_W > DAT_W) begin : g_bad_cnt
    $error("error counter width must be 1 to bus width");
  end

  typedef struct packed {
    logic [CTRL_W-1:0]    ctrl;
    logic                 ack;
    logic [DAT_W-1:0]     dat;
    logic [ERR_CNT_W-1:0] err_cnt;
    rrs_rx_state_type     st;
    logic                 phase;
    logic [DIBIT_W-1:0]   nib_hi;
    logic                 nib_err;
    logic                 rx_clk;
    logic [NIB_W-1:0]     rx_data;
    logic                 rx_dv;
    logic                 rx_er;
    logic                 crs;
  } rrs_rx_state_q_type;

  rrs_rx_state_q_type q, n;

  logic rec_level;
  logic rec_fall;
  logic ref_fall;
  logic rmii;
  logic speed100;
  logic tick;
  logic take;
  logic half_mii;
  logic sqe_en;
  logic commit;
  logic err_event;

  function automatic logic reg_hit(input logic [ADR_W-1:0] adr,
                                   input logic [ADR_W-1:0] off);
    reg_hit = adr == off;
  endfunction : reg_hit

  // Both link clocks come from outside and are sampled by clk_i
  rrs_edge_sync u_rec_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (rec_clock_i),
    .level_o (rec_level),
    .rise_o  (),
    .fall_o  (rec_fall)
  );

  rrs_edge_sync u_ref_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (ref_clock_in_i),
    .level_o (),
    .rise_o  (),
    .fall_o  (ref_fall)
  );

  assign rmii     = q.ctrl[CTRL_RMII];
  assign speed100 = q.ctrl[CTRL_SPEED100];
  // Pins change on the falling link edge so the MAC sees them settled at the rising one
  assign tick     = rmii ? ref_fall : rec_fall;
  // RMII consumes one nibble every two reference cycles
  assign take     = tick && (!rmii || !q.phase);
  assign half_mii = !rmii && !q.ctrl[CTRL_FDX];
  assign sqe_en   = half_mii && !speed100 && q.ctrl[CTRL_HB_EN];
  assign commit   = wb_cyc_i && wb_stb_i && q.ack;
  assign err_event = take && core_dv_i && core_err_i;

  rrs_col_gen u_col (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .tx_active_i (core_tx_active_i),
    .carrier_i   (core_carrier_i),
    .half_mii_i  (half_mii),
    .sqe_en_i    (sqe_en),
    .col_o       (col_o)
  );

  always_comb begin
    logic [ERR_CNT_W-1:0] cnt;
    cnt = '0;
    n   = q;

    // Wishbone: answer one cycle after the request, drop ack the cycle after
    n.ack = wb_cyc_i && wb_stb_i && !q.ack;
    n.dat = '0;
    if (reg_hit(wb_adr_i, ADDR_CTRL)) begin
      n.dat[CTRL_W-1:0] = q.ctrl;
    end else if (reg_hit(wb_adr_i, ADDR_STAT)) begin
      n.dat[STAT_CARRIER] = q.crs;
      n.dat[STAT_DV]      = q.rx_dv;
      n.dat[STAT_COL]     = col_o;
      n.dat[STAT_ER]      = q.rx_er;
      n.dat[STAT_DRAIN]   = q.st == RRS_DRAIN;
    end else if (reg_hit(wb_adr_i, ADDR_ERRCNT)) begin
      n.dat[ERR_CNT_W-1:0] = q.err_cnt;
    end

    if (commit && wb_we_i && reg_hit(wb_adr_i, ADDR_CTRL) && wb_sel_i[0]) begin
      n.ctrl = wb_dat_i[CTRL_W-1:0];
    end

    // A counted error in the clearing cycle survives the clear
    cnt = q.err_cnt;
    if (commit && wb_we_i && reg_hit(wb_adr_i, ADDR_ERRCNT)) begin
      cnt = '0;
    end
    if (err_event && cnt != '1) begin
      cnt = cnt + 1'b1;
    end
    n.err_cnt = cnt;

    // Recovered clock is passed out in MII only; RMII leaves the pin low
    n.rx_clk = rmii ? 1'b0 : rec_level;

    if (tick) begin
      if (!rmii) begin
        n.phase   = 1'b0;
        n.rx_dv   = core_dv_i;
        n.rx_data = core_dv_i ? core_data_i : '0;
        n.rx_er   = core_dv_i && core_err_i && speed100;
        n.crs     = core_carrier_i;
        n.st      = core_dv_i ? RRS_FRAME : RRS_IDLE;
      end else if (!q.phase) begin
        n.nib_hi  = core_data_i[NIB_W-1:DIBIT_W];
        n.nib_err = core_dv_i && core_err_i;
        n.rx_dv   = core_dv_i;
        n.rx_er   = core_dv_i && core_err_i && speed100;
        n.rx_data = '0;
        if (core_dv_i) begin
          n.rx_data[DIBIT_W-1:0] = core_err_i ? CORRUPT_DIBIT : core_data_i[DIBIT_W-1:0];
        end
        // Carrier gone with data left: merged signal low on the first dibit
        n.crs   = core_carrier_i;
        n.phase = core_dv_i;
        if (!core_dv_i) begin
          n.st = RRS_IDLE;
        end else begin
          n.st = core_carrier_i ? RRS_FRAME : RRS_DRAIN;
        end
      end else begin
        n.rx_data = '0;
        n.rx_data[DIBIT_W-1:0] = q.nib_err ? CORRUPT_DIBIT : q.nib_hi;
        // High on the second dibit while draining, so it toggles at half rate
        n.crs   = q.crs || q.st == RRS_DRAIN;
        n.phase = 1'b0;
      end
    end

    case (q.st)
      RRS_IDLE, RRS_FRAME, RRS_DRAIN: begin
      end
      default: begin
        n.st = RRS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q      <= '0;
      q.ctrl <= CTRL_RESET;
      q.st   <= RRS_IDLE;
    end else begin
      q <= n;
    end
  end

  // Data lines stay zero outside valid data
  assign rx_data_o   = q.rx_data;
  assign rx_dv_o     = q.rx_dv;
  assign rx_er_o     = q.rx_er;
  assign crs_o       = q.crs;
  assign rx_clk_o    = q.rx_clk;
  assign wb_dat_o    = q.dat;
  assign wb_ack_o    = q.ack;
  assign core_take_o = take;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence drain_second;
    tick && rmii && q.phase && q.st == RRS_DRAIN;
  endsequence

  sequence drain_first;
    take && rmii && core_dv_i && !core_carrier_i;
  endsequence

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than a cycle");
  er_needs_dv_a: assert property (rx_er_o |-> rx_dv_o)
    else $error("receive error without data valid");
  mii_er_cause_a: assert property (tick && !rmii && core_dv_i && core_err_i && speed100
                                   |=> rx_er_o)
    else $error("MII invalid symbol not flagged");
  rmii_er_cause_a: assert property (take && rmii && core_dv_i && core_err_i && speed100
                                    |=> rx_er_o)
    else $error("RMII media error not flagged");
  rmii_corrupt_a: assert property (take && rmii && core_dv_i && core_err_i
                                   |=> rx_data_o[1:0] == CORRUPT_DIBIT)
    else $error("RMII data not corrupted on error");
  mii_nibble_a: assert property (tick && !rmii && core_dv_i
                                 |=> rx_dv_o && rx_data_o == $past(core_data_i))
    else $error("MII nibble not passed out");
  mii_crs_a: assert property (tick && !rmii |=> crs_o == $past(core_carrier_i))
    else $error("carrier sense does not follow medium");
  rmii_hi_dibit_a: assert property (tick && rmii && q.phase && !q.nib_err
                                    |=> rx_data_o[1:0] == $past(q.nib_hi))
    else $error("RMII second dibit wrong");
  drain_high_a: assert property (drain_second |=> crs_o && rx_dv_o)
    else $error("merged signal low on second dibit while draining");
  drain_low_a: assert property (drain_first |=> !crs_o && rx_dv_o)
    else $error("data valid not independent of carrier");
  idle_quiet_a: assert property (tick && !core_dv_i && !q.phase |=> !rx_dv_o && !rx_er_o)
    else $error("valid or error outside a frame");
  fdx_col_zero_a: assert property (!half_mii ##1 !half_mii |-> !col_o)
    else $error("collision in full duplex or RMII");
  rxclk_follow_a: assert property (!rmii |=> rx_clk_o == $past(rec_level))
    else $error("receive clock not passed out");
endmodule : rrs_rx_signal

// [test/rrs_mac_model.sv]
// Behavioural MAC receiver that records what it samples on the receive pins
`timescale 1ns/1ns
module rrs_mac_model (
  // Sampling clock and own transmit enable
  input  wire logic       link_clk_i,
  input  wire logic       tx_en_i,
  // Receive pins
  input  wire logic [3:0] rx_data_i,
  input  wire logic       rx_dv_i,
  input  wire logic       rx_er_i,
  input  wire logic       crs_i,
  // Collision as the MAC forms it
  output logic            mac_col_o
);
  logic [5:0] got_q[$];
  // Data lines are ignored unless data valid is high
  always @(posedge link_clk_i) begin
    if (rx_dv_i === 1'b1) begin
      got_q.push_back({crs_i, rx_er_i, rx_data_i});
    end
  end
  // No collision pin in RMII, so carrier and own enable are combined here
  assign mac_col_o = crs_i & tx_en_i;
endmodule : rrs_mac_model

// [test/testbench.sv]
// Self-checking bench for the receive status signalling block
`timescale 1ns/1ns
module testbench;
  import rrs_pkg::*;
  logic        clk, rst, cyc, stb, we, ack, lclk, lclk_en, rmii;
  logic        carrier, dv, err, tx, take, rx_clk, rx_dv, rx_er, crs, col;
  logic [3:0]  adr, sel, core_data, rx_data;
  logic [31:0] wdat, rdat, rd;
  int          errors, n_checks;

  always #4 clk = ~clk;
  // Link clock stands still between frames
  always begin
    #62;
    if (lclk_en || lclk) lclk = ~lclk;
    #63;
    if (lclk_en || lclk) lclk = ~lclk;
  end

  rrs_rx_signal dut_u (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rd), .wb_ack_o(ack),
    .rec_clock_i(lclk), .ref_clock_in_i(lclk), .core_carrier_i(carrier),
    .core_dv_i(dv), .core_data_i(core_data), .core_err_i(err),
    .core_tx_active_i(tx), .core_take_o(take), .rx_clk_o(rx_clk), .rx_data_o(rx_data),
    .rx_dv_o(rx_dv), .rx_er_o(rx_er), .crs_o(crs), .col_o(col)
  );

  rrs_mac_model mac_u (
    .link_clk_i(rmii ? lclk : rx_clk), .tx_en_i(tx), .rx_data_i(rx_data),
    .rx_dv_i(rx_dv), .rx_er_i(rx_er), .crs_i(crs), .mac_col_o()
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    n = 0;
    // Ack is looked at on the rising edge, where read data is taken and the request ends
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rdat = rd;
    if (n >= 50) errors++;
    cyc <= 0; stb <= 0; we <= 0;
  endtask : wb

  task automatic t_regs;
    wb(0, ADDR_CTRL, 32'h0);
    chk(rdat, {28'h0, CTRL_RESET});
    wb(1, 4'hC, 32'hFFFF_FFFF);
    wb(0, 4'hC, 32'h0);
    chk(rdat, 32'h0);
  endtask : t_regs

  // Sends four nibbles, one per take pulse, with carrier per nibble, and compares what the MAC saw
  // In RMII a lost carrier with data left shows low on the first dibit and high on the second
  task automatic frame(input logic [15:0] nib, input logic [3:0] e, input logic [3:0] c);
    int n;
    lclk_en = 1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      dv <= 1; carrier <= c[i]; core_data <= nib[4*i+:4]; err <= e[i];
      n = 0;
      do begin @(negedge clk); n++; end while (take !== 1'b1 && n < 100);
      if (n >= 100) errors++;
    end
    // RMII needs the second dibit sent before valid drops
    repeat (rmii ? 20 : 1) @(posedge clk);
    dv <= 0; carrier <= 0; err <= 0;
    repeat (40) @(posedge clk);
    lclk_en = 0;
    @(negedge clk);
    chk({29'h0, rx_dv, rx_er, crs}, 32'h0);
    if (!rmii) begin
      chk(32'(mac_u.got_q.size()), 32'h4);
      for (int i = 0; i < 4; i++) begin
        chk({26'h0, mac_u.got_q[i]}, {26'h0, c[i], e[i], nib[4*i+:4]});
      end
    end else begin
      chk(32'(mac_u.got_q.size()), 32'h8);
      for (int i = 0; i < 8; i++) begin
        chk({26'h0, mac_u.got_q[i]}, {26'h0, c[i/2] | i[0], e[i/2], 2'h0,
            e[i/2] ? CORRUPT_DIBIT : nib[2*i+:2]});
      end
    end
    mac_u.got_q.delete();
  endtask : frame

  task automatic t_col;
    int n;
    wb(1, ADDR_CTRL, 32'hA);
    tx <= 1; carrier <= 1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({31'h0, col}, 32'h1);
    wb(0, ADDR_STAT, 32'h0);
    chk(rdat, 32'h4);
    // Full duplex at 10 Mb/s: no collision while both are active and no heartbeat after
    wb(1, ADDR_CTRL, 32'hC);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({31'h0, col}, 32'h0);
    @(posedge clk);
    tx <= 0; carrier <= 0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({31'h0, col}, 32'h0);
    wb(1, ADDR_CTRL, 32'h8);
    tx <= 1;
    repeat (3) @(posedge clk);
    tx <= 0;
    n = 0;
    repeat (300) begin
      @(negedge clk);
      if (col === 1'b1) n++;
    end
    chk(32'(n), 32'(HB_CYCLES));
  endtask : t_col

  task automatic stop_test;
    $display("errors %0d n_checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    {clk, cyc, stb, we, lclk, lclk_en, rmii, carrier, dv, err, tx} = '0;
    adr = '0; sel = '0; core_data = '0; wdat = '0; rdat = '0;
    rst = 1; errors = 0; n_checks = 0;
    repeat (10) @(posedge clk);
    rst <= 0;
    t_regs();
    frame(16'h4321, 4'b0000, 4'hF);
    frame(16'hC5A3, 4'b0100, 4'hF);
    wb(0, ADDR_ERRCNT, 32'h0);
    chk(rdat, 32'h1);
    wb(1, ADDR_ERRCNT, 32'h0);
    wb(0, ADDR_ERRCNT, 32'h0);
    chk(rdat, 32'h0);
    wb(1, ADDR_CTRL, 32'hB);
    rmii = 1;
    frame(16'h96A5, 4'b0010, 4'b0011);
    rmii = 0;
    t_col();
    stop_test();
  end

  // Whole run needs about 6 us; this limit leaves ample margin
  initial begin
    #100000;
    errors++;
    stop_test();
  end
endmodule : testbench
